// ---- common/rx_los_pkg.sv ----
// Constants, register map and state layout for the receive loss-of-signal block.
// Assumes one 250 MHz clock domain; every pin input is synchronous to it.
//
// Notes on behaviour
// - inactive signal detect declares loss immediately
// - polarity low: active-low detect; high: active-high
// - alarm output high exactly while loss present
// - mute enabled plus loss forces data zero
// - hardware mode takes mute from pin
// - host mode records loss in status registers
// - host mode takes mute from register bit
// - lock flag follows recovery unit lock
// - aux clock is recovered clock divided 16
// - mode select high picks host mode
// - output disable forces receive data zero
package rx_los_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int unsigned RX_W   = 4;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned EV_W   = 3;
   localparam int unsigned DIV_W  = 4;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h1;
   localparam logic [ADDR_W-1:0] MASK_OFS   = 4'h2;
   localparam logic [ADDR_W-1:0] LIVE_OFS   = 4'h3;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int unsigned CTRL_MUTE_BIT  = 0;
   localparam int unsigned EV_LOS_SET     = 0;
   localparam int unsigned EV_LOS_CLR     = 1;
   localparam int unsigned EV_LOCK_LOST   = 2;
   localparam int unsigned LIVE_LOS_BIT   = 0;
   localparam int unsigned LIVE_LOCK_BIT  = 1;
   localparam int unsigned LIVE_HOST_BIT  = 2;

   // ---------------------------------------------------------------
   // reset values and divider
   // ---------------------------------------------------------------
   localparam logic             CTRL_MUTE_RST = 1'h0;
   localparam logic [EV_W-1:0]  STATUS_RST    = 3'h0;
   localparam logic [EV_W-1:0]  MASK_RST      = 3'h0;
   localparam int unsigned      DIV_RATIO     = 16;
   localparam logic [DIV_W-1:0] DIV_LAST      = 4'hF;
   localparam logic [DIV_W-1:0] DIV_HALF      = 4'h7;

   // state of the top module, aux divider counter excepted
   typedef struct packed {
      logic              los_alarm;
      logic              lock_flag;
      logic [RX_W-1:0]   rx_data;
      logic              mute_ctl;
      logic [EV_W-1:0]   status;
      logic [EV_W-1:0]   mask;
      logic [DATA_W-1:0] rdata;
      logic              irq;
      logic              rec_prev;
   } top_state_s;

endpackage : rx_los_pkg

// ---- common/aux_clk_if.sv ----
// Carrier between the top module and the aux clock divider.
// Assumes both ends sit on clock_i.
interface aux_clk_if;
   logic rec_rise;   // one-cycle pulse per recovered clock rising edge
   logic aux_clk;    // divided clock, from a flip-flop

   modport src (output rec_rise, input aux_clk);
   modport div (input rec_rise, output aux_clk);
endinterface : aux_clk_if

// ---- hdl/aux_clk_div.sv ----
// Divide-by-16 of the recovered clock, counted in recovered rising edges.
// Assumes rec_rise is a one-cycle pulse synchronous to clock_i.
module aux_clk_div
   import rx_los_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic rstn_i,
   aux_clk_if.div    link
);

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic             aux;
   } div_state_s;

   div_state_s st_r;
   div_state_s st_nxt;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   // counter wraps every DIV_RATIO edges, aux is its top bit
   always_comb begin
      st_nxt = st_r;
      if (link.rec_rise) begin
         st_nxt.cnt = (st_r.cnt == DIV_LAST) ? '0 : st_r.cnt + 4'h1;
      end
      st_nxt.aux = st_nxt.cnt[DIV_W-1];
   end

   // state register
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.aux_clk = st_r.aux;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   a_aux_toggle_edge: assert property (
      (link.rec_rise && (st_r.cnt[2:0] == DIV_HALF[2:0])) |=> (link.aux_clk != $past(link.aux_clk)))
      else $error("aux clock did not toggle on eighth edge");
   a_aux_hold_edge: assert property (
      !(link.rec_rise && (st_r.cnt[2:0] == DIV_HALF[2:0])) |=> $stable(link.aux_clk))
      else $error("aux clock toggled off the eighth edge");
   c_aux_rise: cover property ($rose(link.aux_clk));

endmodule : aux_clk_div

// ---- hdl/rx_los_mute.sv ----
// Receive loss-of-signal detection, data mute, lock flag and aux clock.
// Assumes all pins synchronous to clock_i, register port used by one master.
module rx_los_mute
   import rx_los_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   // optical module and mode pins
   input  wire logic              signal_detect_in_i,
   input  wire logic              polarity_sel_i,
   input  wire logic              mute_on_loss_enable_i,
   input  wire logic              control_mode_select_i,
   input  wire logic              rx_output_disable_i,
   // deserialiser and recovery unit
   input  wire logic [RX_W-1:0]   rx_data_i,
   input  wire logic              cdr_locked_i,
   input  wire logic              rec_clk_i,
   // register port
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   // outputs to framer and board
   output logic [RX_W-1:0]        rx_parallel_data_o,
   output logic                   los_alarm_out_o,
   output logic                   recovery_lock_flag_o,
   output logic                   rx_aux_clock_out_o,
   output logic                   irq_o
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // loss is the detect input at its inactive level
   function automatic logic los_of(input logic sd, input logic pol);
      los_of = pol ? ~sd : sd;
   endfunction : los_of

   // register select decode, used by read and write paths
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   top_state_s st_r;
   top_state_s st_nxt;

   logic            loss_of_signal_condition;
   logic            host_mode;
   logic            mute_eff;
   logic            force_zero;
   logic [EV_W-1:0] ev_set;
   logic            rd_status;

   aux_clk_if aux_link ();

   // ---------------------------------------------------------------
   // condition decode
   // ---------------------------------------------------------------
   // loss condition straight from the pin, no filter
   assign loss_of_signal_condition = los_of(signal_detect_in_i, polarity_sel_i);
   // mode select high picks register control
   assign host_mode  = control_mode_select_i;
   // mute source follows control mode
   assign mute_eff   = host_mode ? st_r.mute_ctl : mute_on_loss_enable_i;
   // disable or muted loss blanks the data
   assign force_zero = rx_output_disable_i || (mute_eff && loss_of_signal_condition);
   assign rd_status  = rd_i && hit(addr_i, STATUS_OFS);

   // events recorded only under register control
   always_comb begin
      ev_set               = '0;
      ev_set[EV_LOS_SET]   = loss_of_signal_condition && !st_r.los_alarm;
      ev_set[EV_LOS_CLR]   = !loss_of_signal_condition && st_r.los_alarm;
      ev_set[EV_LOCK_LOST] = !cdr_locked_i && st_r.lock_flag;
      if (!host_mode) begin
         ev_set = '0;
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // alarm follows the condition both ways
      st_nxt.los_alarm = loss_of_signal_condition;
      // lock flag mirrors the recovery unit
      st_nxt.lock_flag = cdr_locked_i;
      // data path with mute and disable
      if (force_zero) begin
         st_nxt.rx_data = '0;
      end else begin
         st_nxt.rx_data = rx_data_i;
      end
      st_nxt.rec_prev = rec_clk_i;
      // register writes
      if (wr_i && hit(addr_i, CTRL_OFS)) begin
         st_nxt.mute_ctl = wdata_i[CTRL_MUTE_BIT];
      end
      if (wr_i && hit(addr_i, MASK_OFS)) begin
         st_nxt.mask = wdata_i[EV_W-1:0];
      end
      // read clears status, a new event still wins
      st_nxt.status = (rd_status ? STATUS_RST : st_r.status) | ev_set;
      st_nxt.irq    = |(st_nxt.status & st_nxt.mask);
      // read data valid only in the cycle after the strobe
      st_nxt.rdata = '0;
      if (rd_i) begin
         unique case (addr_i)
            CTRL_OFS: begin
               st_nxt.rdata[CTRL_MUTE_BIT] = st_r.mute_ctl;
            end
            STATUS_OFS: begin
               st_nxt.rdata[EV_W-1:0] = st_r.status;
            end
            MASK_OFS: begin
               st_nxt.rdata[EV_W-1:0] = st_r.mask;
            end
            LIVE_OFS: begin
               st_nxt.rdata[LIVE_LOS_BIT]  = st_r.los_alarm;
               st_nxt.rdata[LIVE_LOCK_BIT] = st_r.lock_flag;
               st_nxt.rdata[LIVE_HOST_BIT] = host_mode;
            end
            default: begin
               st_nxt.rdata = '0; // unmapped reads zero
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_r          <= '0;
         st_r.mute_ctl <= CTRL_MUTE_RST;
         st_r.status   <= STATUS_RST;
         st_r.mask     <= MASK_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // aux clock divider
   // ---------------------------------------------------------------
   // edge pulse of the recovered clock drives the divider
   assign aux_link.rec_rise = rec_clk_i && !st_r.rec_prev;

   aux_clk_div aux_clk_div_i (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .link    (aux_link.div)
   );

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign rx_parallel_data_o   = st_r.rx_data;
   assign los_alarm_out_o      = st_r.los_alarm;
   assign recovery_lock_flag_o = st_r.lock_flag;
   assign rx_aux_clock_out_o   = aux_link.aux_clk;
   assign irq_o                = st_r.irq;
   assign rdata_o              = st_r.rdata;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   a_los_immediate: assert property (
      loss_of_signal_condition |=> los_alarm_out_o)
      else $error("loss not flagged on next edge");
   a_pol_active_low: assert property (
      (!polarity_sel_i && signal_detect_in_i) |=> los_alarm_out_o)
      else $error("active-low detect high did not raise alarm");
   a_pol_active_high: assert property (
      (polarity_sel_i && signal_detect_in_i) |=> !los_alarm_out_o)
      else $error("active-high detect high raised alarm");
   a_alarm_tracks: assert property (
      $changed(signal_detect_in_i) && $stable(polarity_sel_i)
      |=> (los_alarm_out_o != $past(los_alarm_out_o)))
      else $error("alarm did not track detect change");
   a_mute_forces: assert property (
      (mute_eff && loss_of_signal_condition) |=> (rx_parallel_data_o == '0))
      else $error("muted loss did not zero data");
   a_mute_off_pass: assert property (
      (!mute_eff && !rx_output_disable_i) |=> (rx_parallel_data_o == $past(rx_data_i)))
      else $error("data blanked with mute disabled");
   a_hw_pin_mute: assert property (
      (!control_mode_select_i && mute_on_loss_enable_i && loss_of_signal_condition)
      |=> (rx_parallel_data_o == '0))
      else $error("pin mute ignored in hardware mode");
   a_host_records: assert property (
      (control_mode_select_i && loss_of_signal_condition && !los_alarm_out_o)
      |=> st_r.status[EV_LOS_SET] ##1 ($past(rd_status) || st_r.status[EV_LOS_SET]))
      else $error("loss not recorded in host mode");
   a_host_reg_mute: assert property (
      (control_mode_select_i && !st_r.mute_ctl && !rx_output_disable_i)
      |=> (rx_parallel_data_o == $past(rx_data_i)))
      else $error("pin mute used in host mode");
   a_lock_follow: assert property (
      $changed(cdr_locked_i) |=> (recovery_lock_flag_o == $past(cdr_locked_i))[*1] ##0
      (recovery_lock_flag_o != $past(recovery_lock_flag_o)))
      else $error("lock flag did not follow recovery unit");
   a_hw_no_record: assert property (
      (!control_mode_select_i && !rd_status) |=> $stable(st_r.status))
      else $error("status changed in hardware mode");
   a_disable_zero: assert property (
      rx_output_disable_i |=> (rx_parallel_data_o == '0))
      else $error("output disable did not zero data");
   a_recover_clear: assert property (
      (!loss_of_signal_condition && !rx_output_disable_i)
      |=> (!los_alarm_out_o && (rx_parallel_data_o == $past(rx_data_i))))
      else $error("recovery did not clear alarm and mute");
   a_irq_masked: assert property (
      ((st_r.mask == '0) && !(wr_i && hit(addr_i, MASK_OFS))) |=> !irq_o)
      else $error("interrupt with all sources masked");

   // ---------------------------------------------------------------
   // register port checks
   // ---------------------------------------------------------------
   // read data is zero outside the cycle after a read
   a_rdata_idle: assert property (
      !rd_i |=> (rdata_o == '0))
      else $error("read data not zero outside a read");
   // control write lands on the next edge
   a_ctrl_write: assert property (
      (wr_i && hit(addr_i, CTRL_OFS)) |=> (st_r.mute_ctl == $past(wdata_i[CTRL_MUTE_BIT])))
      else $error("control write did not land");
   a_ctrl_read: assert property (
      (rd_i && hit(addr_i, CTRL_OFS))
      |=> (rdata_o == DATA_W'($past(st_r.mute_ctl))))
      else $error("control read returned wrong value");
   // mask write lands and reads back alone
   a_mask_write: assert property (
      (wr_i && hit(addr_i, MASK_OFS)) |=> (st_r.mask == $past(wdata_i[EV_W-1:0])))
      else $error("mask write did not land");
   a_mask_read: assert property (
      (rd_i && hit(addr_i, MASK_OFS)) |=> (rdata_o == DATA_W'($past(st_r.mask))))
      else $error("mask read returned wrong value");
   // status read returns the pending events, then clears them
   a_status_read: assert property (
      rd_status |=> (rdata_o == DATA_W'($past(st_r.status))))
      else $error("status read returned wrong value");
   a_read_clears: assert property (
      (rd_status && (ev_set == '0)) |=> (st_r.status == '0))
      else $error("status read did not clear");
   // an event in the read cycle survives the clear
   a_set_wins: assert property (
      (rd_status && (ev_set != '0)) |=> (st_r.status == $past(ev_set)))
      else $error("event lost to status read");
   // status holds while nothing happens
   a_status_hold: assert property (
      (!rd_status && (ev_set == '0)) |=> $stable(st_r.status))
      else $error("status changed with no event");
   // live and unmapped reads
   a_live_read: assert property (
      (rd_i && hit(addr_i, LIVE_OFS))
      |=> (rdata_o == DATA_W'({$past(host_mode), $past(recovery_lock_flag_o),
                               $past(los_alarm_out_o)})))
      else $error("live read returned wrong value");
   a_unmapped_read: assert property (
      (rd_i && (addr_i > LIVE_OFS)) |=> (rdata_o == '0))
      else $error("unmapped read not zero");
   // host mode events and interrupt
   a_host_loss_end: assert property (
      (control_mode_select_i && !loss_of_signal_condition && los_alarm_out_o)
      |=> st_r.status[EV_LOS_CLR])
      else $error("loss end not recorded in host mode");
   a_lock_event: assert property (
      (control_mode_select_i && !cdr_locked_i && recovery_lock_flag_o)
      |=> st_r.status[EV_LOCK_LOST])
      else $error("lock loss not recorded in host mode");
   a_irq_raise: assert property (
      (((ev_set & st_r.mask) != '0) && !(wr_i && hit(addr_i, MASK_OFS))) |=> irq_o)
      else $error("unmasked event did not raise interrupt");
   a_irq_drop: assert property (
      (rd_status && (ev_set == '0)) |=> !irq_o)
      else $error("interrupt held after status read");
   // lock flag drops with the recovery unit
   a_lock_low: assert property (
      !cdr_locked_i |=> !recovery_lock_flag_o)
      else $error("lock flag high while out of lock");
   // every data bit blanks on its own
   for (genvar b = 0; b < RX_W; b++) begin : g_bit_chk
      a_bit_blank: assert property (
         force_zero |=> !rx_parallel_data_o[b])
         else $error("data bit left set while blanked");
   end

   c_los_then_recover: cover property (
      $rose(los_alarm_out_o) ##[1:20] $fell(los_alarm_out_o));
   c_host_mute: cover property (
      control_mode_select_i && st_r.mute_ctl && loss_of_signal_condition);
   c_status_read_clear: cover property (
      rd_status && (st_r.status != '0) ##1 (st_r.status == '0));
   c_lock_lost_irq: cover property ($fell(recovery_lock_flag_o) ##[1:3] irq_o);

endmodule : rx_los_mute

// ---- tb/optic_model.sv ----
// Far-side model: optical module signal detect and recovered line clock.
// Assumes the bench clock_i; the recovered clock runs free, as a line clock does.
module optic_model (
   input  wire logic clock_i,
   input  wire logic rstn_i,
   input  wire logic present_i,
   input  wire logic pol_i,
   input  wire logic fec_i,
   output logic      signal_detect_o,
   output logic      rec_clk_o
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam int HALF_STD = 4;
   localparam int HALF_FEC = 3;

   int half_cnt;

   // active level follows polarity choice of the board
   assign signal_detect_o = present_i ? pol_i : ~pol_i;

   // recovered clock, faster when the line carries the fec rate
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         half_cnt  <= 0;
         rec_clk_o <= 1'b0;
      end else if (half_cnt >= (fec_i ? HALF_FEC : HALF_STD) - 1) begin
         half_cnt  <= 0;
         rec_clk_o <= ~rec_clk_o;
      end else begin
         half_cnt <= half_cnt + 1;
      end
   end
endmodule : optic_model

// ---- tb/rx_los_mute_tb.sv ----
// Self-checking bench for the receive loss-of-signal block.
// Assumes rx_los_pkg compiled first; drives pins and register port at posedge.
module rx_los_mute_tb
   import rx_los_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic              clock_i = 1'b0;
   logic              rstn_i = 1'b0;
   logic              present = 1'b1, pol = 1'b0, fec = 1'b0, sd, rec;
   logic              mute_pin = 1'b0, mode = 1'b0, dis = 1'b0, cdr = 1'b1;
   logic [RX_W-1:0]   rx_data = 4'h0, rxo;
   logic [ADDR_W-1:0] addr = 4'h0;
   logic [DATA_W-1:0] wdata = 8'h00, rdata, v;
   logic              wr = 1'b0, rd = 1'b0, alarm, lockf, aux, irq, rec_q, aux_q;
   logic [31:0]       seed = 32'd35;
   int                miscompares = 0, comparisons = 0, cycles = 0, pulses, toggles = 0, t0;

   rx_los_mute rx_los_mute_i (.clock_i(clock_i), .rstn_i(rstn_i), .signal_detect_in_i(sd),
      .polarity_sel_i(pol), .mute_on_loss_enable_i(mute_pin), .control_mode_select_i(mode),
      .rx_output_disable_i(dis), .rx_data_i(rx_data), .cdr_locked_i(cdr), .rec_clk_i(rec),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .rx_parallel_data_o(rxo), .los_alarm_out_o(alarm), .recovery_lock_flag_o(lockf),
      .rx_aux_clock_out_o(aux), .irq_o(irq));
   optic_model optic_model_i (.clock_i(clock_i), .rstn_i(rstn_i), .present_i(present),
      .pol_i(pol), .fec_i(fec), .signal_detect_o(sd), .rec_clk_o(rec));

   always #2 clock_i = ~clock_i;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // expected data word after mute and disable
   function automatic logic [7:0] exp_data(input logic [RX_W-1:0] d, input logic loss,
                                           input logic mute, input logic off);
      return (off || (loss && mute)) ? 8'h00 : {4'h0, d};
   endfunction : exp_data

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clock_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic wait_n(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : wait_n

   task automatic tally_and_finish();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   // aux clock watch: eight recovered rising edges between toggles
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pulses = 0;
         rec_q  = 1'b0;
         aux_q  = 1'b0;
      end else begin
         if (aux !== aux_q) begin
            chk(8'(pulses), 8'(DIV_RATIO / 2));
            pulses = 0;
            toggles++;
         end
         if (rec && !rec_q) pulses++;
         rec_q = rec;
         aux_q = aux;
      end
   end

   // hang guard
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clock_i);
      rstn_i <= 1'b1;
      // detect, polarity, mode and mute in every combination, twice
      for (int i = 0; i < 32; i++) begin
         wr_reg(CTRL_OFS, 8'(~i[0] ^ i[3])); // register and pin disagree in both modes
         @(posedge clock_i);
         pol      <= i[1];
         present  <= i[2];
         mode     <= i[3];
         mute_pin <= i[0] ^ i[3];
         rx_data  <= RX_W'(xs());
         wait_n(1);
         chk(alarm, !i[2]);
         chk(rxo, exp_data(rx_data, !i[2], i[0], 1'b0));
      end
      $display("test detect and mute done");
      // output disable wins over detect and mute for the data; alarm still follows detect
      for (int i = 0; i < 6; i++) begin
         @(posedge clock_i);
         dis     <= 1'b1;
         present <= xs() % 2;
         rx_data <= RX_W'(xs());
         wait_n(1);
         chk(rxo, 8'h00);
         chk(alarm, !present);
      end
      dis     <= 1'b0;
      present <= 1'b1;
      $display("test disable done");
      // lock flag follows recovery unit
      for (int i = 0; i < 8; i++) begin
         @(posedge clock_i);
         cdr <= xs() % 2;
         wait_n(1);
         chk(lockf, cdr);
      end
      cdr <= 1'b1;
      $display("test lock done");
      // status, mask and interrupt in host mode
      mode <= 1'b1;
      pol  <= 1'b0;
      wr_reg(MASK_OFS, 8'h07);
      wait_n(3);
      rd_reg(STATUS_OFS, v);
      wait_n(2);
      chk(irq, 1'b0);
      @(posedge clock_i);
      present <= 1'b0;
      wait_n(3);
      chk(irq, 1'b1);
      rd_reg(STATUS_OFS, v);
      chk(v, 8'(1 << EV_LOS_SET));
      wait_n(2);
      chk(irq, 1'b0);
      present <= 1'b1;
      wait_n(3);
      rd_reg(STATUS_OFS, v);
      chk(v, 8'(1 << EV_LOS_CLR));
      cdr <= 1'b0;
      wait_n(3);
      rd_reg(STATUS_OFS, v);
      chk(v, 8'(1 << EV_LOCK_LOST));
      rd_reg(LIVE_OFS, v);
      chk(v, 8'(1 << LIVE_HOST_BIT));
      cdr <= 1'b1;
      wr_reg(MASK_OFS, 8'h00);
      present <= 1'b0;
      wait_n(3);
      chk(irq, 1'b0);
      rd_reg(STATUS_OFS, v);
      chk(v, 8'(1 << EV_LOS_SET));
      rd_reg(4'h5, v);
      chk(v, 8'h00);
      // status ignores writes; an event in the read cycle survives it
      wr_reg(STATUS_OFS, 8'hFF);
      rd_reg(STATUS_OFS, v);
      chk(v, 8'h00);
      fork
         rd_reg(STATUS_OFS, v);
         begin
            @(posedge clock_i);
            present <= 1'b1;
         end
      join
      chk(v, 8'h00);
      rd_reg(STATUS_OFS, v);
      chk(v, 8'(1 << EV_LOS_CLR));
      wr_reg(CTRL_OFS, 8'hFF);
      rd_reg(CTRL_OFS, v);
      chk(v, 8'h01);
      wr_reg(MASK_OFS, 8'hFA);
      rd_reg(MASK_OFS, v);
      chk(v, 8'h02);
      mode    <= 1'b0;
      present <= 1'b0;
      wait_n(3);
      rd_reg(STATUS_OFS, v);
      chk(v, 8'h00);
      $display("test status done");
      // aux clock at both line rates
      for (int r = 0; r < 2; r++) begin
         fec <= r[0];
         t0 = toggles;
         wait_n(600);
         chk(8'(toggles > t0 + 2), 8'h01);
      end
      $display("test aux clock done");
      tally_and_finish();
   end
endmodule : rx_los_mute_tb
